// ===== design/asp_consts.svh
// Constants of the asynchronous serial port: register indices, field
// positions, reset values and timing counts.
// Assumes an AXI4-Lite slave whose byte address is four times the index.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// Register indices (byte address = 4 * index)
`define ASP_IDX_CTRL1 16'h000E
`define ASP_IDX_STATUS 16'h000E
`define ASP_IDX_TXBUF 16'h0F9C
`define ASP_IDX_CTRL2 16'h0010
`define ASP_IDX_RXBUF 16'h0F9D

// Reset values
`define ASP_CTRL1_RST 8'h00
`define ASP_CTRL2_RST 8'h00
`define ASP_TXBUF_RST 8'h00
`define ASP_RXBUF_RST 8'h00

// serial_ctrl1 fields
`define ASP_C1_TX_EN 7
`define ASP_C1_RX_EN 6
`define ASP_C1_STOP2 5
`define ASP_C1_EVEN 4
`define ASP_C1_PAR_ADD 3
`define ASP_C1_BAUD_HI 2
`define ASP_C1_BAUD_LO 0

// serial_ctrl2 fields
`define ASP_C2_RX_STOP2 2
`define ASP_C2_NF_HI 1
`define ASP_C2_NF_LO 0

// serial_status fields
`define ASP_ST_PARITY_ERR_FLAG 7
`define ASP_ST_FRAME_ERR_FLAG 6
`define ASP_ST_OVR 5
`define ASP_ST_FULL 4
`define ASP_ST_DONE 3
`define ASP_ST_EMPTY 2

// Baud divisors in source clock cycles, and the timer source code
`define ASP_DIV_000 9'd13
`define ASP_DIV_001 9'd26
`define ASP_DIV_010 9'd52
`define ASP_DIV_011 9'd104
`define ASP_DIV_100 9'd208
`define ASP_DIV_101 9'd416
`define ASP_DIV_111 9'd96
`define ASP_BAUD_TIMER 3'h6

// Noise rejection: shortest accepted pulse in source clock cycles
`define ASP_NF_CYC_01 7'd31
`define ASP_NF_CYC_10 7'd63
`define ASP_NF_CYC_11 7'd127

// Receive sample points within a bit, and frame length without options
`define ASP_SAMPLE_A 7
`define ASP_SAMPLE_B 8
`define ASP_SAMPLE_C 9
`define ASP_FRAME_BASE 4'hA

// AXI responses
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2

`endif

// ===== design/asp_pkg.sv
// Types shared by the asynchronous serial port.
// Assumes the constants header is on the include path.
package asp_pkg;
  typedef enum logic {ASP_TX_IDLE, ASP_TX_BUSY} asp_tx_state_e;
  typedef enum logic {ASP_RX_IDLE, ASP_RX_BUSY} asp_rx_state_e;
endpackage : asp_pkg

// ===== design/asp_serial_port.sv
// Asynchronous serial port: AXI4-Lite register slave, baud generator,
// receive noise filter, transmitter and majority-vote receiver.
// Assumes one clock (source clock = ref_clk) and synchronous inputs.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_serial_port
  import asp_pkg::*;
#(
  parameter int RT_PER_BIT = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic timer5_tick,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_irq,
  output logic rx_irq,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int RTW = $clog2(RT_PER_BIT);

  if (RT_PER_BIT < 10 || RT_PER_BIT > 256) begin : g_bad_rt
    $error("RT_PER_BIT must lie between 10 and 256");
  end

  function automatic logic [15:0] word_idx(input logic [17:0] a);
    return a[17:2];
  endfunction : word_idx

  function automatic logic [8:0] baud_div(input logic [2:0] sel);
    logic [8:0] d;
    d = `ASP_DIV_111;
    unique case (sel)
      3'h0: d = `ASP_DIV_000;
      3'h1: d = `ASP_DIV_001;
      3'h2: d = `ASP_DIV_010;
      3'h3: d = `ASP_DIV_011;
      3'h4: d = `ASP_DIV_100;
      3'h5: d = `ASP_DIV_101;
      default: d = `ASP_DIV_111;
    endcase
    return d;
  endfunction : baud_div

  // Register, flag and bus state
  logic [7:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
  logic [7:0] tx_buf_reg, tx_buf_next, rx_buf_reg, rx_buf_next;
  logic tx_pend_reg, tx_pend_next, tx_empty_reg, tx_empty_next;
  logic tx_done_reg, tx_done_next, rx_full_reg, rx_full_next;
  logic ovr_reg, ovr_next, parity_err_flag_reg, parity_err_flag_next, frame_err_flag_reg, frame_err_flag_next;
  logic tx_arm_reg, tx_arm_next, rx_arm_reg, rx_arm_next;
  logic ovr_seen_reg, ovr_seen_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [15:0] aw_idx_reg, aw_idx_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] rdata_reg, rdata_next;

  // Line engine state
  logic [8:0] bdiv_reg, bdiv_next;
  logic rxf_reg, rxf_next;
  logic [6:0] nf_cnt_reg, nf_cnt_next;
  asp_tx_state_e tx_st_reg, tx_st_next;
  logic [11:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_nb_reg, tx_nb_next;
  logic [RTW-1:0] tx_rt_reg, tx_rt_next;
  logic tx_pin_reg, tx_pin_next, tx_irq_reg, tx_irq_next;
  asp_rx_state_e rx_st_reg, rx_st_next;
  logic [11:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [RTW-1:0] rx_rt_reg, rx_rt_next;
  logic [1:0] rx_vote_reg, rx_vote_next;
  logic rx_irq_reg, rx_irq_next;

  // Events from the line engines to the flags
  logic rt_tick, tx_start, tx_fin, tx_drop, rx_load, rx_ovr;
  logic rx_parity_err_flag, rx_frame_err_flag;
  logic [7:0] rx_data;

  logic aw_fire, w_fire, ar_fire, wr_go;
  logic [15:0] wr_idx, rd_idx;
  logic [7:0] wr_data;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign tx_pin = tx_pin_reg;
  assign tx_irq = tx_irq_reg;
  assign rx_irq = rx_irq_reg;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_go = (aw_have_reg || aw_fire) && (w_have_reg || w_fire);
  assign wr_idx = aw_have_reg ? aw_idx_reg : word_idx(s_axi_awaddr);
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata[7:0];
  assign rd_idx = word_idx(s_axi_araddr);

  // Bus slave, registers and status flags
  always_comb begin
    logic lane;
    lane = w_have_reg ? w_lane_reg : s_axi_wstrb[0];
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    tx_buf_next = tx_buf_reg;
    rx_buf_next = rx_buf_reg;
    tx_pend_next = tx_pend_reg;
    tx_empty_next = tx_empty_reg;
    tx_done_next = tx_done_reg;
    rx_full_next = rx_full_reg;
    ovr_next = ovr_reg;
    parity_err_flag_next = parity_err_flag_reg;
    frame_err_flag_next = frame_err_flag_reg;
    tx_arm_next = tx_arm_reg;
    rx_arm_next = rx_arm_reg;
    ovr_seen_next = ovr_seen_reg;
    aw_have_next = aw_have_reg || aw_fire;
    aw_idx_next = aw_fire ? word_idx(s_axi_awaddr) : aw_idx_reg;
    w_have_next = w_have_reg || w_fire;
    w_data_next = w_fire ? s_axi_wdata[7:0] : w_data_reg;
    w_lane_next = w_fire ? s_axi_wstrb[0] : w_lane_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;

    // Transmit engine moves the buffer out, or drops it while transmit is disabled
    if (tx_start) begin
      tx_pend_next = 1'b0;
      tx_empty_next = 1'b1;
      tx_done_next = 1'b0;
    end
    if (tx_drop) begin
      tx_pend_next = 1'b0;
      tx_empty_next = 1'b1;
    end

    if (wr_go) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `ASP_RESP_OKAY;
      unique case (wr_idx)
        `ASP_IDX_CTRL1: if (lane) ctrl1_next = wr_data;
        `ASP_IDX_CTRL2: if (lane) ctrl2_next = wr_data;
        `ASP_IDX_TXBUF: begin
          // Without the arming status read the write is dropped
          if (lane && tx_arm_reg) begin
            tx_buf_next = wr_data;
            tx_pend_next = 1'b1;
            tx_empty_next = 1'b0;
            tx_arm_next = 1'b0;
          end
        end
        default: bresp_next = `ASP_RESP_SLVERR;
      endcase
    end

    if (ar_fire) begin
      rvalid_next = 1'b1;
      rresp_next = `ASP_RESP_OKAY;
      rdata_next = 8'h00;
      unique case (rd_idx)
        `ASP_IDX_STATUS: begin
          rdata_next = {parity_err_flag_reg, frame_err_flag_reg, ovr_reg, rx_full_reg,
                        tx_done_reg, tx_empty_reg, 2'b00};
          tx_arm_next = 1'b1;
          rx_arm_next = 1'b1;
          ovr_seen_next = ovr_reg;
        end
        `ASP_IDX_RXBUF: begin
          rdata_next = rx_buf_reg;
          if (rx_arm_reg) begin
            parity_err_flag_next = 1'b0;
            frame_err_flag_next = 1'b0;
            rx_full_next = 1'b0;
            if (ovr_seen_reg) begin
              ovr_next = 1'b0;
            end
            rx_arm_next = 1'b0;
          end
        end
        `ASP_IDX_CTRL2, `ASP_IDX_TXBUF: rdata_next = 8'h00;
        default: rresp_next = `ASP_RESP_SLVERR;
      endcase
    end

    // Hardware sets win over software clears in the same cycle
    if (tx_fin && !tx_pend_next) begin
      tx_done_next = 1'b1;
    end
    if (rx_load) begin
      rx_buf_next = rx_data;
      rx_full_next = 1'b1;
      if (rx_parity_err_flag) begin
        parity_err_flag_next = 1'b1;
      end
      if (rx_frame_err_flag) begin
        frame_err_flag_next = 1'b1;
      end
    end
    if (rx_ovr) begin
      ovr_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= `ASP_CTRL1_RST;
      ctrl2_reg <= `ASP_CTRL2_RST;
      tx_buf_reg <= `ASP_TXBUF_RST;
      rx_buf_reg <= `ASP_RXBUF_RST;
      tx_pend_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      tx_done_reg <= 1'b1;
      rx_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      parity_err_flag_reg <= 1'b0;
      frame_err_flag_reg <= 1'b0;
      tx_arm_reg <= 1'b0;
      rx_arm_reg <= 1'b0;
      ovr_seen_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ASP_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `ASP_RESP_OKAY;
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      tx_buf_reg <= tx_buf_next;
      rx_buf_reg <= rx_buf_next;
      tx_pend_reg <= tx_pend_next;
      tx_empty_reg <= tx_empty_next;
      tx_done_reg <= tx_done_next;
      rx_full_reg <= rx_full_next;
      ovr_reg <= ovr_next;
      parity_err_flag_reg <= parity_err_flag_next;
      frame_err_flag_reg <= frame_err_flag_next;
      tx_arm_reg <= tx_arm_next;
      rx_arm_reg <= rx_arm_next;
      ovr_seen_reg <= ovr_seen_next;
      aw_have_reg <= aw_have_next;
      aw_idx_reg <= aw_idx_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Baud tick and receive noise filter
  always_comb begin
    logic [8:0] div;
    logic [6:0] thr;
    div = baud_div(ctrl1_reg[`ASP_C1_BAUD_HI:`ASP_C1_BAUD_LO]);
    thr = `ASP_NF_CYC_01;
    // One tick source feeds both directions
    if (ctrl1_reg[`ASP_C1_BAUD_HI:`ASP_C1_BAUD_LO] == `ASP_BAUD_TIMER) begin
      rt_tick = timer5_tick;
      bdiv_next = 9'h000;
    end else begin
      rt_tick = (bdiv_reg >= div - 9'h001);
      bdiv_next = rt_tick ? 9'h000 : bdiv_reg + 9'h001;
    end
    unique case (ctrl2_reg[`ASP_C2_NF_HI:`ASP_C2_NF_LO])
      2'h1: thr = `ASP_NF_CYC_01;
      2'h2: thr = `ASP_NF_CYC_10;
      2'h3: thr = `ASP_NF_CYC_11;
      default: thr = `ASP_NF_CYC_01;
    endcase
    rxf_next = rxf_reg;
    nf_cnt_next = 7'h00;
    if (ctrl2_reg[`ASP_C2_NF_HI:`ASP_C2_NF_LO] == 2'h0) begin
      rxf_next = rx_pin;
    end else if (rx_pin != rxf_reg) begin
      // A level must hold thr cycles to pass; longer pulses always do
      if (nf_cnt_reg + 7'h01 >= thr) begin
        rxf_next = rx_pin;
      end else begin
        nf_cnt_next = nf_cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bdiv_reg <= 9'h000;
      rxf_reg <= 1'b1;
      nf_cnt_reg <= 7'h00;
    end else if (clk_en) begin
      bdiv_reg <= bdiv_next;
      rxf_reg <= rxf_next;
      nf_cnt_reg <= nf_cnt_next;
    end
  end

  // Transmitter
  always_comb begin
    logic [11:0] fr;
    fr = 12'hFFF;
    tx_st_next = tx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_nb_next = tx_nb_reg;
    tx_rt_next = tx_rt_reg;
    tx_start = 1'b0;
    tx_fin = 1'b0;
    tx_drop = 1'b0;
    unique case (tx_st_reg)
      ASP_TX_IDLE: begin
        if (tx_pend_reg && ctrl1_reg[`ASP_C1_TX_EN]) begin
          fr[0] = 1'b0;
          fr[8:1] = tx_buf_reg;
          if (ctrl1_reg[`ASP_C1_PAR_ADD]) begin
            fr[9] = ctrl1_reg[`ASP_C1_EVEN] ? ^tx_buf_reg : ~^tx_buf_reg;
          end
          tx_sh_next = fr;
          tx_nb_next = `ASP_FRAME_BASE
                     + {3'b000, ctrl1_reg[`ASP_C1_PAR_ADD]}
                     + {3'b000, ctrl1_reg[`ASP_C1_STOP2]};
          tx_rt_next = '0;
          tx_start = 1'b1;
          tx_st_next = ASP_TX_BUSY;
        end else if (tx_pend_reg) begin
          tx_drop = 1'b1;
        end
      end
      ASP_TX_BUSY: begin
        // Enable is only looked at between frames
        if (rt_tick) begin
          if (tx_rt_reg == RTW'(RT_PER_BIT - 1)) begin
            tx_rt_next = '0;
            tx_sh_next = {1'b1, tx_sh_reg[11:1]};
            tx_nb_next = tx_nb_reg - 4'h1;
            if (tx_nb_reg == 4'h1) begin
              tx_fin = 1'b1;
              tx_st_next = ASP_TX_IDLE;
            end
          end else begin
            tx_rt_next = tx_rt_reg + RTW'(1);
          end
        end
      end
    endcase
    tx_pin_next = (tx_st_next == ASP_TX_BUSY) ? tx_sh_next[0] : 1'b1;
    tx_irq_next = tx_start;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg <= ASP_TX_IDLE;
      tx_sh_reg <= 12'hFFF;
      tx_nb_reg <= 4'h0;
      tx_rt_reg <= '0;
      tx_pin_reg <= 1'b1;
      tx_irq_reg <= 1'b0;
    end else if (clk_en) begin
      tx_st_reg <= tx_st_next;
      tx_sh_reg <= tx_sh_next;
      tx_nb_reg <= tx_nb_next;
      tx_rt_reg <= tx_rt_next;
      tx_pin_reg <= tx_pin_next;
      tx_irq_reg <= tx_irq_next;
    end
  end

  // Receiver
  always_comb begin
    logic [1:0] votes;
    logic bitv, pe;
    logic [3:0] nb;
    logic [11:0] fr;
    pe = ctrl1_reg[`ASP_C1_PAR_ADD];
    nb = `ASP_FRAME_BASE + {3'b000, pe}
       + {3'b000, ctrl2_reg[`ASP_C2_RX_STOP2]};
    votes = rx_vote_reg + {1'b0, rxf_reg};
    bitv = votes[1];
    fr = rx_sh_reg;
    fr[rx_bit_reg] = bitv;
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_bit_next = rx_bit_reg;
    rx_rt_next = rx_rt_reg;
    rx_vote_next = rx_vote_reg;
    rx_load = 1'b0;
    rx_ovr = 1'b0;
    rx_data = fr[8:1];
    rx_parity_err_flag = pe && (fr[9] != (ctrl1_reg[`ASP_C1_EVEN] ? ^fr[8:1]
                                                      : ~^fr[8:1]));
    rx_frame_err_flag = !fr[4'h9 + {3'b000, pe}]
            || (ctrl2_reg[`ASP_C2_RX_STOP2]
                && !fr[4'hA + {3'b000, pe}]);
    unique case (rx_st_reg)
      ASP_RX_IDLE: begin
        // Disable and overrun only gate the start of a new frame
        if (rt_tick && !rxf_reg && ctrl1_reg[`ASP_C1_RX_EN]
            && !ovr_reg) begin
          rx_st_next = ASP_RX_BUSY;
          rx_rt_next = RTW'(1);
          rx_bit_next = 4'h0;
          rx_vote_next = 2'h0;
          rx_sh_next = 12'h000;
        end
      end
      ASP_RX_BUSY: begin
        if (rt_tick) begin
          rx_rt_next = (rx_rt_reg == RTW'(RT_PER_BIT - 1))
                     ? '0 : rx_rt_reg + RTW'(1);
          if (rx_rt_reg == RTW'(`ASP_SAMPLE_A)
              || rx_rt_reg == RTW'(`ASP_SAMPLE_B)) begin
            rx_vote_next = votes;
          end else if (rx_rt_reg == RTW'(`ASP_SAMPLE_C)) begin
            rx_vote_next = 2'h0;
            rx_sh_next = fr;
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && bitv) begin
              rx_st_next = ASP_RX_IDLE; // False start rejected
            end else if (rx_bit_reg == nb - 4'h1) begin
              rx_st_next = ASP_RX_IDLE;
              if (rx_full_reg) begin
                rx_ovr = 1'b1;
              end else begin
                rx_load = 1'b1;
              end
            end
          end
        end
      end
    endcase
    rx_irq_next = rx_load;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg <= ASP_RX_IDLE;
      rx_sh_reg <= 12'h000;
      rx_bit_reg <= 4'h0;
      rx_rt_reg <= '0;
      rx_vote_reg <= 2'h0;
      rx_irq_reg <= 1'b0;
    end else if (clk_en) begin
      rx_st_reg <= rx_st_next;
      rx_sh_reg <= rx_sh_next;
      rx_bit_reg <= rx_bit_next;
      rx_rt_reg <= rx_rt_next;
      rx_vote_reg <= rx_vote_next;
      rx_irq_reg <= rx_irq_next;
    end
  end

endmodule : asp_serial_port

// ===== test/asp_port_properties.sv
// Checker for serial pins and register bus handshakes of the port.
// Assumes it is bound to asp_serial_port; one clock domain.
`timescale 1ns/1ps
module asp_port_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tx_pin,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A frame spans hundreds of cycles, so two starts within eight is a bug
  a_txirq_once: assert property (tx_irq |=> !tx_irq [*8])
    else $error("tx_irq repeated too soon");
  a_start_low: assert property (tx_irq |-> !tx_pin [*8])
    else $error("start bit not low");
  a_rxirq_once: assert property (rx_irq |=> !rx_irq [*8])
    else $error("rx_irq repeated too soon");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_wr_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rd_byte: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule : asp_port_props

// ===== test/asp_remote_dev.sv
// Remote serial device: sends frames on the receive line and captures
// the transmit line. Assumes tasks are called right after a clock edge.
`timescale 1ns/1ps
module asp_remote_dev #(
  parameter int BIT_CYC = 208
) (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'h1;
  task automatic wait_bit();
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask : wait_bit
  // Always carries a parity bit; stop may be sent low to force an error
  task automatic send(input logic [7:0] d, input logic par,
                      input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      wait_bit();
    end
    rx_line <= 1'h1;
    wait_bit();
  endtask : send
  task automatic grab(output logic [10:0] f);
    @(negedge tx_line);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = tx_line;
      wait_bit();
    end
  endtask : grab
endmodule : asp_remote_dev

// ===== test/asp_serial_port_tb.sv
// Bench: register tasks over the bus, remote device on the serial lines.
// Assumes design, checker and remote device files are compiled first.
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_serial_port_tb;
  localparam logic [17:0] A_ST = {`ASP_IDX_STATUS, 2'h0};
  localparam logic [17:0] A_C1 = {`ASP_IDX_CTRL1, 2'h0};
  localparam logic [17:0] A_C2 = {`ASP_IDX_CTRL2, 2'h0};
  localparam logic [17:0] A_TX = {`ASP_IDX_TXBUF, 2'h0};
  localparam logic [17:0] A_RX = {`ASP_IDX_RXBUF, 2'h0};
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic rx_pin, tx_pin, tx_irq, rx_irq;
  logic [17:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0, rdata, got;
  logic [1:0] bresp, rresp, resp, wresp;
  logic [10:0] frame;
  int miscompares = 0, checks_done = 0, n_tx = 0, n_rx = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (tx_irq === 1'h1) n_tx++;
    if (rx_irq === 1'h1) n_rx++;
  end
  asp_serial_port dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1),
    .timer5_tick(1'h0), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'h1)
  );
  asp_remote_dev #(.BIT_CYC(16 * 13)) far_u (
    .ref_clk(ref_clk), .tx_line(tx_pin), .rx_line(rx_pin)
  );
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Readies are read at the falling edge: inputs move only at the rising
  // edge, so that value is what the next rising edge samples
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    tb = 1'h0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      wresp = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
  endtask : wr
  task automatic rd(input logic [17:0] a);
    logic ta, tb;
    tb = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = arready;
      tb = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'h0;
    end
  endtask : rd
  task automatic rc(input logic [17:0] a, input string what,
                    input logic [31:0] exp);
    rd(a);
    chk(what, exp, got);
  endtask : rc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rc(A_ST, "status reset", 32'h0C);
    rd(18'h00100);
    chk("unmapped resp", {30'h0, `ASP_RESP_SLVERR}, {30'h0, resp});
    wr(A_C2, 8'h00);
    chk("write resp", {30'h0, `ASP_RESP_OKAY}, {30'h0, wresp});
    wr(A_TX, 8'h11);
    wr(A_C1, 8'hD8);
    wr(A_TX, 8'h22);
    repeat (300) @(posedge ref_clk);
    chk("tx starts", 32'h0, n_tx);
    rc(A_ST, "status guard", 32'h0C);
    $display("test tx_guard finished");
    fork
      far_u.grab(frame);
      begin
        rd(A_ST);
        wr(A_TX, 8'hA5);
        rc(A_ST, "status sending", 32'h04);
      end
    join
    chk("tx frame", {21'h0, 2'h2, 8'hA5, 1'h0}, {21'h0, frame});
    chk("tx starts", 32'h1, n_tx);
    rc(A_ST, "status sent", 32'h0C);
    $display("test tx_frame finished");
    far_u.send(8'h3C, 1'h0, 1'h1);
    rc(A_ST, "status rx", 32'h1C);
    rc(A_RX, "rx data", 32'h3C);
    rc(A_ST, "status cleared", 32'h0C);
    $display("test rx_frame finished");
    far_u.send(8'h5A, 1'h1, 1'h0);
    rc(A_ST, "status errors", 32'hDC);
    rc(A_RX, "rx data", 32'h5A);
    rc(A_ST, "status cleared", 32'h0C);
    $display("test rx_errors finished");
    far_u.send(8'h81, 1'h0, 1'h1);
    far_u.send(8'h7E, 1'h0, 1'h1);
    rc(A_ST, "status overrun", 32'h3C);
    rc(A_RX, "rx kept", 32'h81);
    rc(A_ST, "status cleared", 32'h0C);
    chk("rx irqs", 32'h3, n_rx);
    $display("test overrun finished");
    report_and_stop();
  end
endmodule : asp_serial_port_tb
bind asp_serial_port asp_port_props chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .tx_pin(tx_pin),
  .tx_irq(tx_irq), .rx_irq(rx_irq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
);
